// >>> src/lcs_link_ctl.v
// Local design decisions: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "lcs_consts.vh"
module lcs_link_ctl (
    // Clock and resets
    input wire clk_i,
    input wire rst_i,
    input wire warm_rst_i,
    input wire cold_rst_i,
    // Mode strap pins
    input wire [1:0] mode_i,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output wire wb_ack_o,
    // Link events from link logic: init done is a level, the others are one-cycle pulses
    input wire proto_err_i,
    input wire [3:0] lane_check_err_i,
    input wire link_fail_det_i,
    input wire init_done_i,
    input wire test_done_i,
    // Link controls
    output wire tx_disable_o,
    output wire drop_toward_link_o,
    output wire nxa_respond_o,
    output wire init_block_o,
    output wire force_bad_check_o,
    output wire test_start_o,
    output wire sync_flood_o,
    // Interrupt
    output wire irq_o
);
    wire [1:0] mode;
    wire wr_ctrl;
    wire wr_istat;
    wire wr_imask;
    wire single;
    wire mode_a;
    wire lo_we;
    wire hi_we;
    wire [15:0] wd;
    wire any_check;
    wire fatal;
    wire hard_rst;
    wire link_rst;
    wire hw_fail;
    reg proto_q;
    reg [3:0] lane_q;
    reg xoff_q;
    reg eoc_q;
    reg init_q;
    reg fail_q;
    reg fail_act_q;
    reg force_q;
    reg test_q;
    reg test_go_q;
    reg flood_en_q;
    reg flood_q;
    reg [`LCS_I_W-1:0] istat_q;
    reg [`LCS_I_W-1:0] imask_q;
    reg [`LCS_I_W-1:0] ev;
    reg [15:0] ctrl_rd;

    // Mode straps from pins
    lcs_sync2 #(.W(2)) u_mode_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(mode_i),
        .q_o(mode)
    );

    // Bus decode and ack
    lcs_wb_slave u_wb (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_ack_o(wb_ack_o),
        .wr_ctrl_o(wr_ctrl),
        .wr_istat_o(wr_istat),
        .wr_imask_o(wr_imask)
    );

    // True in the two single-link modes
    function is_single;
        input [1:0] m;
        begin
            is_single = (m == `LCS_MODE_SP) | (m == `LCS_MODE_GSP);
        end
    endfunction

    // True only in the first single-link mode
    function is_mode_a;
        input [1:0] m;
        begin
            is_mode_a = (m == `LCS_MODE_SP);
        end
    endfunction

    // Sticky flags: a new event beats a write-one clear
    function [3:0] sticky_next;
        input [3:0] cur;
        input [3:0] clr;
        input [3:0] set;
        begin
            sticky_next = (cur & ~clr) | set;
        end
    endfunction

    // Mode decode
    assign single = is_single(mode);
    assign mode_a = is_mode_a(mode);
    // Byte lane write enables on the control word
    assign lo_we = wr_ctrl & wb_sel_i[`LCS_SEL_LO];
    assign hi_we = wr_ctrl & wb_sel_i[`LCS_SEL_HI];
    assign wd = wb_dat_i[`LCS_CTRL_MSB:0];
    assign any_check = |lane_check_err_i;
    assign fatal = flood_en_q & any_check & single;

    // Reset groups and hardware failure events
    assign hard_rst = rst_i | cold_rst_i;
    assign link_rst = rst_i | warm_rst_i | cold_rst_i;
    assign hw_fail = link_fail_det_i | fatal;

    // Sticky protocol error, warm reset does not touch it
    always @(posedge clk_i) begin
        if (hard_rst | ~mode_a) begin
            proto_q <= 1'b0;
        end else if (proto_err_i) begin
            proto_q <= 1'b1;
        end else if (hi_we & wd[`LCS_B_PROTO]) begin
            proto_q <= 1'b0;
        end
    end

    // Per-lane check error flags, set beats clear
    always @(posedge clk_i) begin
        if (hard_rst | ~single) begin
            lane_q <= `LCS_RST_LANE;
        end else begin
            lane_q <= sticky_next(lane_q, {`LCS_LANES{hi_we}}
                & wd[`LCS_B_LANE_HI:`LCS_B_LANE_LO], lane_check_err_i);
        end
    end

    // Controls cleared by link resets: shutoff and chain end set-only, force and flood enable follow each write
    always @(posedge clk_i) begin
        if (link_rst | ~single) begin
            xoff_q <= 1'b0;
            eoc_q <= 1'b0;
            force_q <= 1'b0;
            flood_en_q <= 1'b0;
        end else if (lo_we) begin
            xoff_q <= xoff_q | wd[`LCS_B_XOFF];
            eoc_q <= eoc_q | wd[`LCS_B_EOC];
            force_q <= wd[`LCS_B_FORCE];
            flood_en_q <= wd[`LCS_B_FLOOD];
        end
    end

    // Init done indicator
    always @(posedge clk_i) begin
        if (link_rst) begin
            init_q <= 1'b0;
        end else begin
            init_q <= init_done_i & ~fail_act_q;
        end
    end

    // Link failure flag, survives warm reset
    always @(posedge clk_i) begin
        if (hard_rst | ~single) begin
            fail_q <= 1'b0;
        end else if (hw_fail) begin
            fail_q <= 1'b1;
        end else if (lo_we) begin
            fail_q <= wd[`LCS_B_FAIL];
        end
    end

    // Effective failure: hardware at once, software at warm reset
    always @(posedge clk_i) begin
        if (hard_rst | ~single) begin
            fail_act_q <= 1'b0;
        end else if (hw_fail) begin
            fail_act_q <= 1'b1;
        end else if (warm_rst_i) begin
            fail_act_q <= fail_q;
        end
    end

    // Check test start, cleared by completion or warm reset
    always @(posedge clk_i) begin
        if (link_rst | ~single) begin
            test_q <= 1'b0;
            test_go_q <= 1'b0;
        end else if (lo_we & wd[`LCS_B_TEST] & ~test_q) begin
            test_q <= 1'b1;
            test_go_q <= 1'b1;
        end else begin
            test_go_q <= 1'b0;
            if (test_done_i) begin
                test_q <= 1'b0;
            end
        end
    end

    // Sync flood latch, held until a link reset
    always @(posedge clk_i) begin
        if (link_rst) begin
            flood_q <= 1'b0;
        end else if (fatal) begin
            flood_q <= 1'b1;
        end
    end

    // Link control outputs
    assign tx_disable_o = xoff_q;
    assign drop_toward_link_o = eoc_q;
    assign nxa_respond_o = eoc_q;
    assign init_block_o = fail_act_q;
    assign force_bad_check_o = force_q;
    assign test_start_o = test_go_q;
    assign sync_flood_o = flood_q;

    // Interrupt events
    always @* begin
        ev = `LCS_RST_IRQ;
        ev[`LCS_I_PROTO] = proto_err_i & mode_a;
        ev[`LCS_I_CHECK] = any_check & single;
        ev[`LCS_I_FAIL] = hw_fail & single;
        ev[`LCS_I_TESTDONE] = test_done_i & test_q;
    end

    // Sticky status, write one clears, set wins
    always @(posedge clk_i) begin
        if (rst_i) begin
            istat_q <= `LCS_RST_IRQ;
        end else begin
            istat_q <= sticky_next(istat_q, {`LCS_I_W{wr_istat & wb_sel_i[`LCS_SEL_LO]}}
                & wb_dat_i[`LCS_I_W-1:0], ev);
        end
    end

    // Interrupt mask, plain read and write
    always @(posedge clk_i) begin
        if (rst_i) begin
            imask_q <= `LCS_RST_IRQ;
        end else if (wr_imask & wb_sel_i[`LCS_SEL_LO]) begin
            imask_q <= wb_dat_i[`LCS_I_W-1:0];
        end
    end
    assign irq_o = |(istat_q & imask_q);

    // Control register read view
    always @* begin
        ctrl_rd = `LCS_RST_CTRL;
        ctrl_rd[`LCS_B_PROTO] = proto_q;
        ctrl_rd[`LCS_B_LANE_HI:`LCS_B_LANE_LO] = lane_q;
        ctrl_rd[`LCS_B_XOFF] = xoff_q;
        ctrl_rd[`LCS_B_EOC] = eoc_q;
        ctrl_rd[`LCS_B_INIT] = single ? init_q : 1'b1;
        ctrl_rd[`LCS_B_FAIL] = fail_q;
        ctrl_rd[`LCS_B_FORCE] = force_q;
        ctrl_rd[`LCS_B_TEST] = test_q;
        ctrl_rd[`LCS_B_FLOOD] = flood_en_q;
    end

    // Registered read data
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= `LCS_ZERO32;
        end else begin
            case (wb_adr_i)
                `LCS_ADDR_CTRL: wb_dat_o <= {`LCS_PAD_CTRL, ctrl_rd};
                `LCS_ADDR_ISTAT: wb_dat_o <= {`LCS_PAD_IRQ, istat_q};
                `LCS_ADDR_IMASK: wb_dat_o <= {`LCS_PAD_IRQ, imask_q};
                default: wb_dat_o <= `LCS_ZERO32;
            endcase
        end
    end
endmodule
`default_nettype wire

// >>> src/lcs_consts.vh
`ifndef LCS_CONSTS_VH
`define LCS_CONSTS_VH
// Operating modes
`define LCS_MODE_SP 2'h0
`define LCS_MODE_GSP 2'h1
`define LCS_MODE_DSP 2'h2
`define LCS_MODE_GDP 2'h3
// Register byte addresses
`define LCS_ADDR_CTRL 8'h48
`define LCS_ADDR_ISTAT 8'h4c
`define LCS_ADDR_IMASK 8'h50
// Control register bit positions
`define LCS_B_PROTO 12
`define LCS_B_LANE_LO 8
`define LCS_B_LANE_HI 11
`define LCS_B_XOFF 7
`define LCS_B_EOC 6
`define LCS_B_INIT 5
`define LCS_B_FAIL 4
`define LCS_B_FORCE 3
`define LCS_B_TEST 2
`define LCS_B_FLOOD 1
// Interrupt status bit positions
`define LCS_I_PROTO 0
`define LCS_I_CHECK 1
`define LCS_I_FAIL 2
`define LCS_I_TESTDONE 3
`define LCS_I_W 4
// Reset values
`define LCS_RST_LANE 4'h0
`define LCS_RST_IRQ 4'h0
`define LCS_ZERO32 32'h00000000
`define LCS_RST_CTRL 16'h0000
`define LCS_PAD_CTRL 16'h0000
`define LCS_PAD_IRQ 28'h0000000
// Bus byte lanes and control word width
`define LCS_SEL_LO 0
`define LCS_SEL_HI 1
`define LCS_CTRL_MSB 15
`define LCS_LANES 4
`endif

// >>> src/lcs_sync2.v
`timescale 1ns/1ps
`default_nettype none
module lcs_sync2 #(
    parameter W = 1
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Data
    input wire [W-1:0] d_i,
    output wire [W-1:0] q_o
);
    reg [W-1:0] s1_q;
    reg [W-1:0] s2_q;
    // Two-stage synchroniser, first stage read only by second
    always @(posedge clk_i) begin
        if (rst_i) begin
            s1_q <= {W{1'b0}};
            s2_q <= {W{1'b0}};
        end else begin
            s1_q <= d_i;
            s2_q <= s1_q;
        end
    end
    assign q_o = s2_q;
endmodule
`default_nettype wire

// >>> src/lcs_wb_slave.v
`timescale 1ns/1ps
`default_nettype none
`include "lcs_consts.vh"
module lcs_wb_slave (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Wishbone
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    output reg wb_ack_o,
    // Decoded one-cycle write strobes
    output wire wr_ctrl_o,
    output wire wr_istat_o,
    output wire wr_imask_o
);
    wire req;
    wire wr;
    // One request per ack, ack drops the cycle after
    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req;
        end
    end
    // Write takes effect on the acked edge
    assign wr = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i;
    assign wr_ctrl_o = wr & (wb_adr_i == `LCS_ADDR_CTRL);
    assign wr_istat_o = wr & (wb_adr_i == `LCS_ADDR_ISTAT);
    assign wr_imask_o = wr & (wb_adr_i == `LCS_ADDR_IMASK);
endmodule
`default_nettype wire

// >>> verification/lcs_link_checker.sv
`timescale 1ns/1ps
`default_nettype none
module lcs_link_checker (
    // Clock and resets
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic warm_rst_i,
    input wire logic cold_rst_i,
    input wire logic [1:0] mode_i,
    // Register bus
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Link controls
    input wire logic tx_disable_o,
    input wire logic drop_toward_link_o,
    input wire logic nxa_respond_o,
    input wire logic init_block_o,
    input wire logic test_start_o,
    input wire logic sync_flood_o
);
    // Only link resets may drop sticky controls
    wire logic hold_w = !warm_rst_i && !cold_rst_i;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Read answers of the control register
    sequence s_rd; wb_ack_o && !wb_we_i && wb_adr_i == 8'h48; endsequence
    sequence s_dual; s_rd ##0 mode_i[1]; endsequence
    property p_ack; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("ack longer than one cycle");
    property p_rsv; s_rd |-> wb_dat_o[0] == 1'b0; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bit set");
    property p_b12; s_rd ##0 (mode_i != 2'h0) |-> !wb_dat_o[12]; endproperty
    a_b12: assert property (p_b12) else $error("bit 12 set outside mode A");
    property p_dual; s_dual |-> wb_dat_o[12:5] == 8'h01; endproperty
    a_dual: assert property (p_dual) else $error("dual mode read wrong");
    property p_xoff; tx_disable_o && hold_w |=> tx_disable_o; endproperty
    a_xoff: assert property (p_xoff) else $error("shutoff dropped");
    property p_eoc; drop_toward_link_o && hold_w |=> drop_toward_link_o; endproperty
    a_eoc: assert property (p_eoc) else $error("chain end dropped");
    property p_nxa; drop_toward_link_o |-> nxa_respond_o; endproperty
    a_nxa: assert property (p_nxa) else $error("no error response");
    property p_fail; init_block_o && hold_w |=> init_block_o; endproperty
    a_fail: assert property (p_fail) else $error("init block dropped");
    property p_flood; sync_flood_o && hold_w |=> sync_flood_o; endproperty
    a_flood: assert property (p_flood) else $error("flood dropped");
    property p_start; test_start_o |=> !test_start_o; endproperty
    a_start: assert property (p_start) else $error("start pulse too long");
endmodule
bind lcs_link_ctl lcs_link_checker i_lcs_link_checker (
    .clk_i(clk_i), .rst_i(rst_i), .warm_rst_i(warm_rst_i), .cold_rst_i(cold_rst_i),
    .mode_i(mode_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .tx_disable_o(tx_disable_o), .init_block_o(init_block_o),
    .drop_toward_link_o(drop_toward_link_o), .nxa_respond_o(nxa_respond_o),
    .test_start_o(test_start_o), .sync_flood_o(sync_flood_o));
`default_nettype wire

// >>> verification/lcs_peer_model.sv
`timescale 1ns/1ps
`default_nettype none
module lcs_peer_model #(
    parameter int DLY = 12
) (
    // Clock and resets
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic warm_i,
    // Link controls
    input wire logic block_i,
    input wire logic start_i,
    input wire logic slow_i,
    // Link status
    output logic init_done_o,
    output logic test_done_o
);
    logic [7:0] cnt_q;
    logic [7:0] tst_q;
    // Training ends after a few cycles unless blocked
    always @(posedge clk_i) begin
        if (rst_i || warm_i || block_i)
            cnt_q <= 8'h0;
        else if (cnt_q != 8'h3)
            cnt_q <= cnt_q + 8'h1;
    end
    assign init_done_o = cnt_q == 8'h3;
    // Check test, prompt or slow, ends with one pulse
    always @(posedge clk_i) begin
        test_done_o <= 1'b0;
        if (rst_i || warm_i) begin
            tst_q <= 8'h0;
        end else if (start_i) begin
            tst_q <= slow_i ? 8'(DLY) : 8'h1;
        end else if (tst_q != 8'h0) begin
            tst_q <= tst_q - 8'h1;
            test_done_o <= tst_q == 8'h1;
        end
    end
endmodule
`default_nettype wire

// >>> verification/tb_lcs_link_ctl.sv
`timescale 1ns/1ps
`default_nettype none
module tb_lcs_link_ctl;
    logic clk_i = 0, rst_i = 1, warm = 0, cold = 0, cyc = 0, stb = 0, we = 0, slow = 0;
    logic proto = 0, fdet = 0, ack, txo, drop, nonexistent_target_response, blk, fbad, start, flood, irq, init, tdone;
    logic [1:0] mode = 2'h0;
    logic [3:0] lane = 4'h0, sel = 4'h3;
    logic [7:0] adr = 8'h0;
    logic [31:0] wdat = 32'h0, rdat, rd_q;
    int err_count = 0, checks = 0, starts = 0;
    initial begin
        forever #25 clk_i = ~clk_i;
    end
    lcs_link_ctl i_lcs_link_ctl (
        .clk_i(clk_i), .rst_i(rst_i), .warm_rst_i(warm), .cold_rst_i(cold), .mode_i(mode),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .proto_err_i(proto),
        .lane_check_err_i(lane), .link_fail_det_i(fdet), .init_done_i(init),
        .test_done_i(tdone), .tx_disable_o(txo), .drop_toward_link_o(drop),
        .nxa_respond_o(nonexistent_target_response), .init_block_o(blk), .force_bad_check_o(fbad),
        .test_start_o(start), .sync_flood_o(flood), .irq_o(irq));
    lcs_peer_model i_lcs_peer_model (
        .clk_i(clk_i), .rst_i(rst_i), .warm_i(warm), .block_i(blk), .start_i(start),
        .slow_i(slow), .init_done_o(init), .test_done_o(tdone));
    // Counts launch pulses of the check test
    always @(posedge clk_i) begin
        if (start === 1'b1) starts <= starts + 1;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("wrong value at %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // One classic bus cycle, held until ack
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
                      input logic [3:0] s = 4'h3);
        int n;
        n = 0;
        @(posedge clk_i);
        {cyc, stb, we, adr, wdat, sel} <= {2'h3, w, a, d, s};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        rd_q = rdat;
        {cyc, stb} <= 2'h0;
        if (n >= 20) begin
            err_count++;
            end_of_test();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(a, 1'b1, d);
    endtask
    task automatic rdc(input logic [31:0] m, input logic [31:0] e);
        wb(8'h48, 1'b0, 32'h0);
        chk(rd_q & m, e);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic ev(input logic [5:0] e);
        @(posedge clk_i);
        {fdet, lane, proto} <= e;
        @(posedge clk_i);
        {fdet, lane, proto} <= 6'h0;
        tick(2);
    endtask
    task automatic pulse_rst(input logic [1:0] m, input int which);
        @(posedge clk_i);
        if (which == 0) rst_i <= 1'b1; else if (which == 1) warm <= 1'b1; else cold <= 1'b1;
        mode <= m;
        tick(which == 0 ? 10 : 1);
        {rst_i, warm, cold} <= 3'h0;
        tick(6);
    endtask
    task automatic t_proto();
        rdc(32'h1fff, 32'h20);
        wb(8'h60, 1'b0, 32'h0);
        chk(rd_q, 32'h0);
        ev(6'h01);
        wr(8'h48, 32'h1);
        rdc(32'h1fff, 32'h1020);
        pulse_rst(2'h0, 1);
        rdc(32'h1fff, 32'h1020);
        wb(8'h48, 1'b1, 32'h1000, 4'h1);
        rdc(32'h1fff, 32'h1020);
        wr(8'h50, 32'h1);
        tick(1);
        chk(32'(irq), 32'h1);
        wr(8'h50, 32'h0);
        tick(1);
        chk(32'(irq), 32'h0);
        wr(8'h4c, 32'hf);
        wr(8'h48, 32'h1000);
        rdc(32'h1fff, 32'h20);
        ev(6'h1e);
        wr(8'h48, 32'h500);
        rdc(32'h1fff, 32'ha20);
        $display("protocol and lane test done");
    endtask
    task automatic t_chain();
        wr(8'h48, 32'h40);
        tick(2);
        chk(32'({txo, drop, nonexistent_target_response}), 32'h3);
        wr(8'h48, 32'h80);
        tick(2);
        chk(32'({txo, drop, nonexistent_target_response}), 32'h7);
        wr(8'h48, 32'h0);
        rdc(32'h1fff, 32'hae0);
        pulse_rst(2'h0, 1);
        chk(32'({txo, drop}), 32'h0);
        wr(8'h48, 32'hc0);
        pulse_rst(2'h0, 2);
        chk(32'(txo), 32'h0);
        $display("chain end test done");
    endtask
    task automatic t_fail();
        wr(8'h48, 32'h10);
        tick(2);
        chk(32'(blk), 32'h0);
        pulse_rst(2'h0, 1);
        chk(32'(blk), 32'h1);
        rdc(32'h1fff, 32'h10);
        wr(8'h48, 32'h0);
        chk(32'(blk), 32'h1);
        pulse_rst(2'h0, 1);
        rdc(32'h1fff, 32'h20);
        ev(6'h20);
        chk(32'(blk), 32'h1);
        rdc(32'h1fdf, 32'h10);
        wr(8'h48, 32'h0);
        pulse_rst(2'h0, 1);
        wr(8'h4c, 32'hf);
        $display("link failure test done");
    endtask
    task automatic t_test();
        slow <= 1'b1;
        wr(8'h48, 32'h4);
        rdc(32'h1fff, 32'h24);
        chk(starts, 32'h1);
        tick(14);
        rdc(32'h1fff, 32'h20);
        wb(8'h4c, 1'b0, 32'h0);
        chk(rd_q, 32'h8);
        wr(8'h48, 32'h4);
        pulse_rst(2'h0, 1);
        rdc(32'h1fff, 32'h20);
        wr(8'h48, 32'ha);
        tick(2);
        chk(32'(fbad), 32'h1);
        ev(6'h02);
        chk(32'({flood, blk}), 32'h3);
        rdc(32'h1fdf, 32'h11a);
        pulse_rst(2'h0, 1);
        chk(32'({fbad, flood}), 32'h0);
        $display("check test done");
    endtask
    task automatic t_modes();
        for (int m = 1; m < 4; m++) begin
            pulse_rst(2'(m), 0);
            ev(6'h03);
            rdc(32'h1fff, m == 1 ? 32'h120 : 32'h20);
        end
        $display("mode test done");
    endtask
    initial begin
        pulse_rst(2'h0, 0);
        t_proto();
        t_chain();
        t_fail();
        t_test();
        t_modes();
        end_of_test();
    end
endmodule
`default_nettype wire
